// ==== rtl/ofc_defs.svh ====
// Register offsets, field positions, reset value, swing-on code and midcode for the offset/mode block.
`ifndef OFC_DEFS_SVH
`define OFC_DEFS_SVH
`define OFC_ADDR_CHA_SHIFT 8'h00
`define OFC_ADDR_CHB_SHIFT 8'h04
`define OFC_ADDR_LOOP_CTRL 8'h08
`define OFC_ADDR_TUNE_A 8'h0c
`define OFC_ADDR_TUNE_B 8'h10
`define OFC_ADDR_TUNE_C 8'h14
`define OFC_ADDR_TUNE_D 8'h18
`define OFC_ADDR_SLOW_MASTER 8'h1c
`define OFC_ADDR_SWING_EN 8'h20
`define OFC_ADDR_CHA_SLOW 8'h24
`define OFC_ADDR_CORR_EN 8'h28
`define OFC_ADDR_SWING_LVL 8'h2c
`define OFC_ADDR_CHA_SAMPLE 8'h30
`define OFC_ADDR_CHB_SAMPLE 8'h34
`define OFC_ADDR_STATUS 8'h38
`define OFC_SHIFT_MSB 7
`define OFC_SHIFT_LSB 2
`define OFC_HOLD_BIT 7
`define OFC_TAU_MSB 5
`define OFC_TAU_LSB 2
`define OFC_CORR_EN_BIT 5
`define OFC_TUNE_A_BIT 5
`define OFC_TUNE_B_HI_BIT 5
`define OFC_TUNE_B_LO_BIT 1
`define OFC_TUNE_C_MSB 7
`define OFC_TUNE_C_LSB 5
`define OFC_CHB_SLOW_BIT 0
`define OFC_SLOW_MASTER_BIT 4
`define OFC_CHA_SLOW_BIT 3
`define OFC_SWING_EN_ON 2'h3
`define OFC_RESET_BYTE 8'h00
`define OFC_MIDCODE 14'h2000
`endif

// ==== rtl/ofc_pkg.sv ====
// Types shared by the offset/mode configuration block.
package ofc_pkg;
	typedef logic [13:0] ofc_code_t;
	typedef logic [7:0] ofc_byte_t;
	typedef enum logic [1:0] {
		OFC_SWING_OFF = 2'b00,
		OFC_SWING_BAD1 = 2'b01,
		OFC_SWING_BAD2 = 2'b10,
		OFC_SWING_ON = 2'b11
	} ofc_swing_e;
endpackage

// ==== rtl/ofc_corr_chan.sv ====
// One channel of the offset correction loop with pedestal.
`timescale 1ns/10ps
`include "ofc_defs.svh"
module ofc_corr_chan
	import ofc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic corr_enable,
	input wire logic hold,
	input wire logic [3:0] tau,
	input wire logic [5:0] dc_shift,
	input wire ofc_pkg::ofc_code_t sample_in,
	output ofc_pkg::ofc_code_t sample_out
);
	import ofc_pkg::*;

	// Estimate carries 8 fraction bits so small errors still move it.
	logic signed [23:0] est_r;
	logic signed [23:0] err;
	logic signed [14:0] target;
	logic signed [15:0] corrected;

	// Target is midcode plus the signed pedestal, sign extended.
	always_comb begin
		target = 15'($signed({1'b0, `OFC_MIDCODE})) + 15'($signed(dc_shift));
		err = 24'($signed({1'b0, sample_in}) - target) <<< 8;
	end

	// The estimate tracks only when enabled and not frozen; frozen keeps last value.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			est_r <= '0;
		end else if (!corr_enable) begin
			est_r <= '0;
		end else if (!hold) begin
			est_r <= est_r + ((err - est_r) >>> tau);
		end
	end

	// Correction applied every cycle while enabled, bypassed when disabled; saturate to code range to avoid wrap.
	always_comb begin
		corrected = 16'($signed({2'b00, sample_in})) - 16'(est_r >>> 8);
		if (!corr_enable) begin
			corrected = 16'($signed({2'b00, sample_in}));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_out <= '0;
		end else if (corrected < 0) begin
			sample_out <= '0;
		end else if (corrected > 16'sh3fff) begin
			sample_out <= 14'h3fff;
		end else begin
			sample_out <= corrected[13:0];
		end
	end
endmodule

// ==== rtl/ofc_cfg_regs.sv ====
// APB register bank for pedestal, correction loop, tuning, low-speed and swing controls.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "ofc_defs.svh"
// Contract
// - Each six-bit pedestal is signed, -32 to +31, and is added to the midcode.
// - With correction on, output converges to midcode plus that channel's pedestal.
// - Each channel has its own pedestal register at its own address.
// - Hold bit set with correction on freezes the estimate and applies it every cycle.
// - Hold bit clear with correction on keeps the estimate updating.
// - The loop time constant comes from bits 5 to 2 of the loop control register.
// - The three-bit tuning field in bits 7 to 5 is default at 000 and enabled at 111.
// - Bit 0 enables channel B low speed, relied on only after the master enable.
// - Bit 3 enables channel A low speed, relied on only after the master enable.
// - Master low-speed bit 4 at zero forces low speed off for both channels.
// - Swing level is honoured only when the swing enable is 11, ignored at 00.
// - Correction runs only while its enable bit is one.
module ofc_cfg_regs
	import ofc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ofc_pkg::ofc_code_t cha_sample_in,
	input wire ofc_pkg::ofc_code_t chb_sample_in,
	output ofc_pkg::ofc_code_t cha_sample_out,
	output ofc_pkg::ofc_code_t chb_sample_out,
	output logic [10:0] perf_tune_bits,
	output logic [2:0] perf_tune_group_on,
	output logic cha_slow_rate,
	output logic chb_slow_rate,
	output logic swing_ctrl_active,
	output logic [7:0] swing_level
);
	import ofc_pkg::*;

	ofc_byte_t cha_dc_shift_r;
	ofc_byte_t chb_dc_shift_r;
	ofc_byte_t loop_ctrl_r;
	ofc_byte_t tune_a_r;
	ofc_byte_t tune_b_r;
	ofc_byte_t tune_c_r;
	ofc_byte_t tune_d_r;
	ofc_byte_t slow_master_r;
	ofc_byte_t swing_en_r;
	ofc_byte_t cha_slow_r;
	ofc_byte_t corr_en_r;
	ofc_byte_t swing_lvl_r;
	ofc_code_t cha_in_r1;
	ofc_code_t cha_in_r2;
	ofc_code_t chb_in_r1;
	ofc_code_t chb_in_r2;
	logic wr_en;
	logic hit;
	logic [31:0] rd_nxt;
	ofc_swing_e swing_mode;
	logic corr_enable;
	logic hold;
	logic [3:0] tau;

	// Zero wait states: every access completes in its first access cycle.
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;

	// Sample inputs come from the converter clock domain, so synchronise both stages.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cha_in_r1 <= '0;
			cha_in_r2 <= '0;
			chb_in_r1 <= '0;
			chb_in_r2 <= '0;
		end else begin
			cha_in_r1 <= cha_sample_in;
			cha_in_r2 <= cha_in_r1;
			chb_in_r1 <= chb_sample_in;
			chb_in_r2 <= chb_in_r1;
		end
	end

	// Register writes; reserved bits are stored as written and rely on software zeroing.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cha_dc_shift_r <= `OFC_RESET_BYTE;
			chb_dc_shift_r <= `OFC_RESET_BYTE;
			loop_ctrl_r <= `OFC_RESET_BYTE;
			tune_a_r <= `OFC_RESET_BYTE;
			tune_b_r <= `OFC_RESET_BYTE;
			tune_c_r <= `OFC_RESET_BYTE;
			tune_d_r <= `OFC_RESET_BYTE;
			slow_master_r <= `OFC_RESET_BYTE;
			swing_en_r <= `OFC_RESET_BYTE;
			cha_slow_r <= `OFC_RESET_BYTE;
			corr_en_r <= `OFC_RESET_BYTE;
			swing_lvl_r <= `OFC_RESET_BYTE;
		end else if (wr_en) begin
			case (paddr)
				`OFC_ADDR_CHA_SHIFT: cha_dc_shift_r <= pwdata[7:0];
				`OFC_ADDR_CHB_SHIFT: chb_dc_shift_r <= pwdata[7:0];
				`OFC_ADDR_LOOP_CTRL: loop_ctrl_r <= pwdata[7:0];
				`OFC_ADDR_TUNE_A: tune_a_r <= pwdata[7:0];
				`OFC_ADDR_TUNE_B: tune_b_r <= pwdata[7:0];
				`OFC_ADDR_TUNE_C: tune_c_r <= pwdata[7:0];
				`OFC_ADDR_TUNE_D: tune_d_r <= pwdata[7:0];
				`OFC_ADDR_SLOW_MASTER: slow_master_r <= pwdata[7:0];
				`OFC_ADDR_SWING_EN: swing_en_r <= pwdata[7:0];
				`OFC_ADDR_CHA_SLOW: cha_slow_r <= pwdata[7:0];
				`OFC_ADDR_CORR_EN: corr_en_r <= pwdata[7:0];
				`OFC_ADDR_SWING_LVL: swing_lvl_r <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// Read decode; unmapped addresses read zero and flag an error.
	always_comb begin
		rd_nxt = 32'h0000_0000;
		hit = 1'b1;
		case (paddr)
			`OFC_ADDR_CHA_SHIFT: rd_nxt = {24'h00_0000, cha_dc_shift_r};
			`OFC_ADDR_CHB_SHIFT: rd_nxt = {24'h00_0000, chb_dc_shift_r};
			`OFC_ADDR_LOOP_CTRL: rd_nxt = {24'h00_0000, loop_ctrl_r};
			`OFC_ADDR_TUNE_A: rd_nxt = {24'h00_0000, tune_a_r};
			`OFC_ADDR_TUNE_B: rd_nxt = {24'h00_0000, tune_b_r};
			`OFC_ADDR_TUNE_C: rd_nxt = {24'h00_0000, tune_c_r};
			`OFC_ADDR_TUNE_D: rd_nxt = {24'h00_0000, tune_d_r};
			`OFC_ADDR_SLOW_MASTER: rd_nxt = {24'h00_0000, slow_master_r};
			`OFC_ADDR_SWING_EN: rd_nxt = {24'h00_0000, swing_en_r};
			`OFC_ADDR_CHA_SLOW: rd_nxt = {24'h00_0000, cha_slow_r};
			`OFC_ADDR_CORR_EN: rd_nxt = {24'h00_0000, corr_en_r};
			`OFC_ADDR_SWING_LVL: rd_nxt = {24'h00_0000, swing_lvl_r};
			`OFC_ADDR_CHA_SAMPLE: rd_nxt = {18'h0_0000, cha_sample_out};
			`OFC_ADDR_CHB_SAMPLE: rd_nxt = {18'h0_0000, chb_sample_out};
			`OFC_ADDR_STATUS: rd_nxt = {25'h000_0000, swing_ctrl_active, chb_slow_rate,
				cha_slow_rate, perf_tune_group_on, corr_enable};
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// Read data is combinational from registered state, valid in the access cycle.
	assign prdata = (psel && !pwrite) ? rd_nxt : 32'h0000_0000;
	assign pslverr = psel && penable && !hit;

	// Correction loop controls.
	assign corr_enable = corr_en_r[`OFC_CORR_EN_BIT];
	assign hold = loop_ctrl_r[`OFC_HOLD_BIT];
	assign tau = loop_ctrl_r[`OFC_TAU_MSB:`OFC_TAU_LSB];

	// Tuning bits gathered into one vector; bit n-1 is tuning bit n.
	assign perf_tune_bits = {tune_d_r[`OFC_TUNE_B_HI_BIT], tune_d_r[`OFC_TUNE_B_LO_BIT],
		tune_c_r[`OFC_TUNE_C_MSB:`OFC_TUNE_C_LSB], tune_b_r[`OFC_TUNE_B_HI_BIT],
		tune_b_r[`OFC_TUNE_B_LO_BIT], tune_a_r[`OFC_TUNE_A_BIT], 3'h0};

	// The three-bit group counts as on only at 111, partial codes fall back to default.
	always_comb begin
		perf_tune_group_on = 3'h0;
		if (tune_c_r[`OFC_TUNE_C_MSB:`OFC_TUNE_C_LSB] == 3'h7) begin
			perf_tune_group_on = 3'h7;
		end
	end

	// Master bit gates both per-channel low-speed bits.
	assign chb_slow_rate = slow_master_r[`OFC_SLOW_MASTER_BIT] &&
		tune_c_r[`OFC_CHB_SLOW_BIT];
	assign cha_slow_rate = slow_master_r[`OFC_SLOW_MASTER_BIT] &&
		cha_slow_r[`OFC_CHA_SLOW_BIT];

	// Reserved swing codes are treated exactly like disabled.
	assign swing_mode = ofc_swing_e'(swing_en_r[1:0]);
	assign swing_ctrl_active = (swing_mode == OFC_SWING_ON);
	assign swing_level = swing_ctrl_active ? swing_lvl_r : 8'h00;

	// One correction loop per channel, each with its own pedestal.
	ofc_corr_chan u_cha (
		.pclk(pclk),
		.presetn(presetn),
		.corr_enable(corr_enable),
		.hold(hold),
		.tau(tau),
		.dc_shift(cha_dc_shift_r[`OFC_SHIFT_MSB:`OFC_SHIFT_LSB]),
		.sample_in(cha_in_r2),
		.sample_out(cha_sample_out)
	);

	ofc_corr_chan u_chb (
		.pclk(pclk),
		.presetn(presetn),
		.corr_enable(corr_enable),
		.hold(hold),
		.tau(tau),
		.dc_shift(chb_dc_shift_r[`OFC_SHIFT_MSB:`OFC_SHIFT_LSB]),
		.sample_in(chb_in_r2),
		.sample_out(chb_sample_out)
	);
endmodule

// ==== verification/ofc_cfg_regs_checker.sv ====
// Concurrent property checker for the offset and mode register bank.
`timescale 1ns/10ps
`include "ofc_defs.svh"
module ofc_cfg_regs_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [10:0] perf_tune_bits,
	input wire logic [2:0] perf_tune_group_on,
	input wire logic cha_slow_rate,
	input wire logic chb_slow_rate,
	input wire logic swing_ctrl_active,
	input wire logic [7:0] swing_level
);
	// One clock domain, so clocking and reset are declared once for all checks.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A write lands at the access edge; its effect shows one cycle later.
	sequence s_wr(a);
		psel && penable && pwrite && paddr == a;
	endsequence
	property p_rst;
		$rose(presetn) |-> !cha_slow_rate && !chb_slow_rate && !swing_ctrl_active
			&& perf_tune_bits == 11'h0 && perf_tune_group_on == 3'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_master_off;
		s_wr(`OFC_ADDR_SLOW_MASTER) ##0 !pwdata[4] |=> !cha_slow_rate && !chb_slow_rate;
	endproperty
	a_master_off: assert property (p_master_off) else $error("slow mode without master");
	property p_chb_off;
		s_wr(`OFC_ADDR_TUNE_C) ##0 !pwdata[0] |=> !chb_slow_rate;
	endproperty
	a_chb_off: assert property (p_chb_off) else $error("channel b slow mode stuck");
	property p_cha_off;
		s_wr(`OFC_ADDR_CHA_SLOW) ##0 !pwdata[3] |=> !cha_slow_rate;
	endproperty
	a_cha_off: assert property (p_cha_off) else $error("channel a slow mode stuck");
	property p_group;
		s_wr(`OFC_ADDR_TUNE_C) ##0 pwdata[7:5] == 3'h7 |=> perf_tune_group_on == 3'h7;
	endproperty
	a_group: assert property (p_group) else $error("tuning group not enabled");
	property p_swing_off;
		s_wr(`OFC_ADDR_SWING_EN) ##0 pwdata[1:0] != 2'h3 |=> !swing_ctrl_active
			&& swing_level == 8'h0;
	endproperty
	a_swing_off: assert property (p_swing_off) else $error("swing honoured");
	property p_swing_on;
		s_wr(`OFC_ADDR_SWING_EN) ##0 pwdata[1:0] == 2'h3 |=> swing_ctrl_active;
	endproperty
	a_swing_on: assert property (p_swing_on) else $error("swing control not active");
	property p_tune_a;
		s_wr(`OFC_ADDR_TUNE_A) |=> perf_tune_bits[3] == $past(pwdata[5]);
	endproperty
	a_tune_a: assert property (p_tune_a) else $error("tuning bit four not updated");
	property p_unmapped;
		psel && penable && paddr > `OFC_ADDR_STATUS |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule
bind ofc_cfg_regs ofc_cfg_regs_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pslverr(pslverr), .perf_tune_bits(perf_tune_bits), .perf_tune_group_on(perf_tune_group_on),
	.cha_slow_rate(cha_slow_rate), .chb_slow_rate(chb_slow_rate),
	.swing_ctrl_active(swing_ctrl_active), .swing_level(swing_level));

// ==== verification/tb.sv ====
// Self-checking bench for the offset and mode register bank.
`timescale 1ns/10ps
`include "ofc_defs.svh"
module tb;
	import ofc_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d;} ofc_row_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
	logic [7:0] paddr, swing_level;
	logic [31:0] pwdata, prdata, rd;
	ofc_code_t cha_sample_in, chb_sample_in, cha_sample_out, chb_sample_out;
	logic [10:0] perf_tune_bits;
	logic [2:0] perf_tune_group_on;
	logic cha_slow_rate, chb_slow_rate, swing_ctrl_active;
	int n_mismatch, compares;
	ofc_row_s rows[12];
	ofc_cfg_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cha_sample_in(cha_sample_in), .chb_sample_in(chb_sample_in),
		.cha_sample_out(cha_sample_out), .chb_sample_out(chb_sample_out),
		.perf_tune_bits(perf_tune_bits), .perf_tune_group_on(perf_tune_group_on),
		.cha_slow_rate(cha_slow_rate), .chb_slow_rate(chb_slow_rate),
		.swing_ctrl_active(swing_ctrl_active), .swing_level(swing_level));
	// Free-running 100 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task close_out();
		$display("Compares %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One APB transfer; ends at a falling edge so the outputs it caused have settled.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		slv = pslverr;
		if (pready !== 1'b1) begin
			n_mismatch++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask
	// The converging loop takes a few cycles, so the wait is bounded, not fixed.
	task wait_out(input logic b, input ofc_code_t exp);
		int i;
		for (i = 0; i < 100; i++) begin
			@(negedge pclk);
			if ((b ? chb_sample_out : cha_sample_out) === exp) break;
		end
		chk(b ? "chb out" : "cha out", 32'(exp), 32'(b ? chb_sample_out : cha_sample_out));
		if (i == 100) close_out();
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cha_sample_in = `OFC_MIDCODE;
		chb_sample_in = `OFC_MIDCODE;
		n_mismatch = 0;
		compares = 0;
		rows = '{'{8'h00, 32'h80}, '{8'h04, 32'h7c}, '{8'h08, 32'hbc}, '{8'h0c, 32'h20},
			'{8'h10, 32'h22}, '{8'h14, 32'he1}, '{8'h18, 32'h22}, '{8'h1c, 32'h10},
			'{8'h20, 32'h03}, '{8'h24, 32'h08}, '{8'h28, 32'h00}, '{8'h2c, 32'h5a}};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// Each register reads zero from reset, then returns what was written.
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 32'h0);
			chk("reset value", 32'h0, rd);
			apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			chk("readback", rows[i].d, rd);
		end
		chk("tune bits", 32'h7f8, 32'(perf_tune_bits));
		chk("tune group", 32'h7, 32'(perf_tune_group_on));
		chk("slow both", 32'h3, {30'h0, cha_slow_rate, chb_slow_rate});
		chk("swing on", 32'h15a, {23'h0, swing_ctrl_active, swing_level});
		apb(1'b1, `OFC_ADDR_SWING_EN, 32'h1);
		chk("swing reserved", 32'h0, {23'h0, swing_ctrl_active, swing_level});
		apb(1'b1, `OFC_ADDR_SLOW_MASTER, 32'h0);
		chk("slow master off", 32'h0, {30'h0, cha_slow_rate, chb_slow_rate});
		apb(1'b1, `OFC_ADDR_SLOW_MASTER, 32'h10);
		apb(1'b1, `OFC_ADDR_CHA_SLOW, 32'h0);
		apb(1'b1, `OFC_ADDR_TUNE_C, 32'he0);
		chk("slow chans off", 32'h0, {30'h0, cha_slow_rate, chb_slow_rate});
		apb(1'b0, 8'h3c, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, slv});
		chk("unmapped data", 32'h0, rd);
		// Datapath: pass-through, convergence to pedestal, freeze, resume, disable.
		@(posedge pclk);
		cha_sample_in <= 14'h2100;
		chb_sample_in <= 14'h1f00;
		wait_out(1'b0, 14'h2100);
		apb(1'b1, `OFC_ADDR_LOOP_CTRL, 32'h0);
		apb(1'b1, `OFC_ADDR_CORR_EN, 32'h20);
		wait_out(1'b0, 14'h1fe0);
		wait_out(1'b1, 14'h201f);
		apb(1'b1, `OFC_ADDR_LOOP_CTRL, 32'h80);
		@(posedge pclk);
		cha_sample_in <= 14'h2200;
		wait_out(1'b0, 14'h20e0);
		repeat (10) @(negedge pclk);
		chk("frozen out", 32'h20e0, 32'(cha_sample_out));
		apb(1'b1, `OFC_ADDR_LOOP_CTRL, 32'h0);
		wait_out(1'b0, 14'h1fe0);
		apb(1'b1, `OFC_ADDR_CORR_EN, 32'h0);
		wait_out(1'b0, 14'h2200);
		// A long time constant must keep the output near the raw code for many cycles.
		apb(1'b1, `OFC_ADDR_LOOP_CTRL, 32'h3c);
		apb(1'b1, `OFC_ADDR_CORR_EN, 32'h20);
		repeat (10) @(negedge pclk);
		chk("long tau", 32'h2200, 32'(cha_sample_out));
		// Mid-run reset: live controls must drop at once, checked at the falling edge before the next rising edge.
		apb(1'b1, `OFC_ADDR_SWING_EN, 32'h3);
		apb(1'b1, `OFC_ADDR_CHA_SLOW, 32'h8);
		chk("pre reset slow", 32'h2, {30'h0, cha_slow_rate, chb_slow_rate});
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		chk("reset swing", 32'h0, {23'h0, swing_ctrl_active, swing_level});
		chk("reset tune", 32'h0, 32'(perf_tune_bits));
		chk("reset slow", 32'h0, {30'h0, cha_slow_rate, chb_slow_rate});
		chk("reset out", 32'h0, 32'(cha_sample_out));
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OFC_ADDR_CHA_SHIFT, 32'h0);
		chk("reset shift", 32'h0, rd);
		apb(1'b0, `OFC_ADDR_LOOP_CTRL, 32'h0);
		chk("reset loop", 32'h0, rd);
		close_out();
	end
endmodule
